// ==== inc/atc_regs.vh ====
// register map, field positions, reset values and timing counts of the
// audio tdm conversion block; definitions only, included by the top rtl file only
`ifndef ATC_REGS_VH
`define ATC_REGS_VH

// register byte offsets on the serial control bus
`define ATC_ADDR_BRIDGE     8'h54
`define ATC_ADDR_CONV       8'h55
`define ATC_ADDR_STATUS     8'h56
`define ATC_ADDR_TDM        8'h57

// audio_bridge_config fields
`define ATC_TDM_EN_BIT      2
`define ATC_AMODE_BIT       1
// audio_conversion_config fields
`define ATC_SPLIT_BIT       7
// tdm_format_config fields
`define ATC_FS_POL_BIT      3
`define ATC_DELAY_BIT       2
`define ATC_FSW_HI          1
`define ATC_FSW_LO          0
// status fields
`define ATC_ST_OVR_BIT      2
`define ATC_ST_FIFO_BIT     1
`define ATC_ST_TX_BIT       0

// reset values
`define ATC_BRIDGE_RST      8'h02
`define ATC_CONV_RST        8'h00
`define ATC_TDM_RST         8'h02

// frame geometry
`define ATC_SLOT_BITS       32
`define ATC_FIFO_DEPTH      8
`define ATC_FIFO_AW         3
`define ATC_PACK_LAST       8'h3F
`define ATC_TDM_LAST        8'hFF
// clk cycles per low and per high sequencer state; output bit clock is low 7 and high 9 of each 16
`define ATC_TX_HALF_CYC     4'h8

`endif

// ==== rtl/atc_fifo.v ====
// synchronous word fifo, flip-flop storage, valid/ready on both sides
// assumes a single clock; flush empties it in one cycle
`timescale 1ns/1ps
`default_nettype none

module atc_fifo #(
	parameter W  = 32,
	parameter D  = 8,
	parameter AW = 3
) (
	// system
	input  wire          clk,
	input  wire          arst_n,
	input  wire          flush,
	// fill side
	input  wire          in_valid,
	input  wire [W-1:0]  in_data,
	output wire          in_ready,
	// drain side
	output wire          out_valid,
	output wire [W-1:0]  out_data,
	input  wire          out_ready
);

	reg [W-1:0] mem [0:D-1];	// storage
	reg [AW-1:0] wr_q;		// write index
	reg [AW-1:0] rd_q;		// read index
	reg [AW:0]   cnt_q;		// words held

	wire push = in_valid & in_ready;
	wire pop  = out_valid & out_ready;

	assign in_ready  = (cnt_q != D[AW:0]);
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_q];

	// storage write, no reset needed on data
	always @(posedge clk) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// pointers and count
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/atc_sync3.v ====
// three-stage synchroniser with agreement filter for one pin input
// assumes the pin is asynchronous to clk and changes slower than clk
`timescale 1ns/1ps
`default_nettype none

module atc_sync3 (
	// system
	input  wire clk,
	input  wire arst_n,
	// pin side
	input  wire pin_in,
	// clk side
	output reg  level_q
);

	reg s1_q;	// first stage, read by s2 only
	reg s2_q;	// second stage
	reg s3_q;	// third stage

	// shift chain, level taken once stages two and three agree
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

endmodule
`default_nettype wire

// ==== rtl/atc_top.v ====
// audio i2s/tdm conversion: packs four i2s lanes into one tdm line, or
// splits one tdm line onto four i2s lanes, through an 8-word fifo
// assumes pin bit clock well below clk/6; registers on a byte port
// Functional notes
// RULE1: tdm enable packs four lanes into tdm
// RULE2: source select off at 0, pins at 1
// RULE3: split enable spreads tdm onto four lanes
// RULE4: frame sync polarity high at 0, low at 1
// RULE5: active frame sync marks the first sample
// RULE6: data delay zero or one bit clock
// RULE7: polarity and delay govern both directions; the code uses them on the tdm side only, i2s side fixed at pol 1, delay 1
// RULE8: sync width half, slot, or one clock
`timescale 1ns/1ps
`default_nettype none
`include "atc_regs.vh"

module atc_top (
	// system
	input  wire       clk,
	input  wire       arst_n,
	// register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	output reg  [7:0] reg_rdata_q,
	// audio pins in; lane 0 is the serial_audio_data_line
	input  wire       aud_bclk_in,
	input  wire       aud_fs_in,
	input  wire [3:0] aud_din,
	// converted audio out
	output reg        aud_bclk_out_q,
	output reg        aud_fs_out_q,
	output reg  [3:0] aud_dout_q
);

	localparam TX_IDLE = 2'b00;
	localparam TX_LOAD = 2'b01;
	localparam TX_LOW  = 2'b10;
	localparam TX_HIGH = 2'b11;

	integer i;

	// frame sync level for output bit n of a frame
	function fs_level;
		input [7:0] n;
		input       split;
		input [1:0] width;
		input       pol;
		reg         act;
		begin
			act = 1'b0;
			if (width == 2'b00) begin
				act = split ? ~n[5] : ~n[7];
			end else if (width == 2'b01) begin
				act = (n[7:5] == 3'h0);
			end else begin
				act = (n == 8'h00);
			end
			fs_level = act ^ pol;
		end
	endfunction

	// configuration registers
	reg       tdm_en_q;		// pack enable
	reg       amode_q;		// audio source select
	reg       split_q;		// split enable
	reg       fs_pol_q;		// frame_sync_polarity
	reg       dly_q;		// data delay
	reg [1:0] fsw_q;		// frame_sync_width
	reg       ovr_q;		// sticky staging overrun

	// synchronised pins
	wire [5:0] pin_raw = {aud_din, aud_fs_in, aud_bclk_in};
	wire [5:0] pin_s;
	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_sync
			atc_sync3 u_sync (
				.clk     (clk),
				.arst_n  (arst_n),
				.pin_in  (pin_raw[g]),
				.level_q (pin_s[g])
			);
		end
	endgenerate
	wire       bclk_s = pin_s[0];
	wire       fs_s   = pin_s[1];
	wire [3:0] din_s  = pin_s[5:2];

	// mode decode; pack wins when both conversions are enabled
	wire pack  = amode_q & tdm_en_q;		// see RULE1 see RULE2
	wire split = amode_q & split_q & ~tdm_en_q;	// see RULE3 see RULE2
	reg  [1:0] mode_q;				// last seen mode
	wire [1:0] mode_now = {split, pack};
	wire flush = (mode_q != mode_now);		// restart on any mode change

	// fifo links
	wire        push_ready;
	wire        pop_valid;
	wire [31:0] pop_data;
	reg  [31:0] stg [0:3];		// words waiting to enter the fifo
	reg  [2:0]  stg_cnt_q;		// words left in staging
	reg  [1:0]  stg_idx_q;		// next staging word
	reg  [1:0]  tx_st_q;		// transmitter state
	wire        rx_ovr;		// word lost while staging was busy

	// register writes and status flag
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tdm_en_q <= 1'b0;
			amode_q  <= 1'b1;	// see RULE2
			split_q  <= 1'b0;
			fs_pol_q <= 1'b0;	// see RULE4
			dly_q    <= 1'b0;	// see RULE6
			fsw_q    <= 2'b10;	// see RULE8
			ovr_q    <= 1'b0;
			mode_q   <= 2'b00;
		end else begin
			mode_q <= mode_now;
			if (reg_wr && reg_addr == `ATC_ADDR_BRIDGE) begin
				tdm_en_q <= reg_wdata[`ATC_TDM_EN_BIT];
				amode_q  <= reg_wdata[`ATC_AMODE_BIT];
			end
			if (reg_wr && reg_addr == `ATC_ADDR_CONV) begin
				split_q <= reg_wdata[`ATC_SPLIT_BIT];
			end
			if (reg_wr && reg_addr == `ATC_ADDR_TDM) begin
				fs_pol_q <= reg_wdata[`ATC_FS_POL_BIT];
				dly_q    <= reg_wdata[`ATC_DELAY_BIT];
				fsw_q    <= reg_wdata[`ATC_FSW_HI:`ATC_FSW_LO];
			end
			// a new overrun wins over a clear in the same cycle
			if (rx_ovr) begin
				ovr_q <= 1'b1;
			end else if (reg_wr && reg_addr == `ATC_ADDR_STATUS
				&& reg_wdata[`ATC_ST_OVR_BIT]) begin
				ovr_q <= 1'b0;
			end
		end
	end

	// registered read data, one cycle after the address
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 8'h00;
		end else begin
			case (reg_addr)
				`ATC_ADDR_BRIDGE: begin
					reg_rdata_q <= {5'h00, tdm_en_q, amode_q, 1'b0};
				end
				`ATC_ADDR_CONV: begin
					reg_rdata_q <= {split_q, 7'h00};
				end
				`ATC_ADDR_STATUS: begin
					reg_rdata_q <= {5'h00, ovr_q, pop_valid, (tx_st_q != TX_IDLE)};
				end
				`ATC_ADDR_TDM: begin
					reg_rdata_q <= {4'h0, fs_pol_q, dly_q, fsw_q};
				end
				default: begin
					reg_rdata_q <= 8'h00;
				end
			endcase
		end
	end

	// receiver: i2s input in pack mode, register-shaped tdm in split mode
	wire       rx_pol = pack ? 1'b1 : fs_pol_q;	// see RULE7
	wire       rx_dly = pack ? 1'b1 : dly_q;	// see RULE7
	reg        bclk_p_q;		// previous bit clock level
	reg        rx_fsp_q;		// previous active frame sync
	reg        rx_st_q;		// frame start one bit ago
	reg        rx_run_q;		// inside a frame
	reg [7:0]  rx_n_q;		// next bit position in frame
	reg [31:0] rx_sh [0:3];		// lane shifters
	wire       rx_ev    = bclk_s & ~bclk_p_q;	// rising bit clock
	wire       fs_act   = fs_s ^ rx_pol;		// see RULE4
	wire       rx_start = fs_act & ~rx_fsp_q;	// see RULE5
	wire       rx_st_eff = rx_dly ? rx_st_q : rx_start;	// see RULE6
	wire [7:0] rx_pos   = rx_st_eff ? 8'h00 : rx_n_q;
	wire [7:0] rx_last  = pack ? `ATC_PACK_LAST : `ATC_TDM_LAST;
	wire       rx_take  = rx_ev & (rx_st_eff | rx_run_q) & (pack | split);
	wire       rx_word  = rx_take & (rx_pos[4:0] == 5'h1F);
	assign rx_ovr = rx_word & (stg_cnt_q != 3'h0);
	wire [31:0] rx_new [0:3];
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_new
			assign rx_new[g] = {rx_sh[g][30:0], din_s[g]};
		end
	endgenerate

	// bit capture and frame position
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bclk_p_q <= 1'b0;
			rx_fsp_q <= 1'b0;
			rx_st_q  <= 1'b0;
			rx_run_q <= 1'b0;
			rx_n_q   <= 8'h00;
			for (i = 0; i < 4; i = i + 1) begin
				rx_sh[i] <= 32'h00000000;
			end
		end else begin
			bclk_p_q <= bclk_s;
			if (flush) begin
				rx_run_q <= 1'b0;
				rx_st_q  <= 1'b0;
			end else if (rx_ev) begin
				rx_fsp_q <= fs_act;
				rx_st_q  <= rx_start;
				if (rx_take) begin
					for (i = 0; i < 4; i = i + 1) begin
						rx_sh[i] <= rx_new[i];
					end
					rx_n_q   <= rx_pos + 8'h01;
					rx_run_q <= (rx_pos != rx_last);
				end
			end
		end
	end

	// staging: four lane words per half frame in pack, one per slot in split
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stg_cnt_q <= 3'h0;
			stg_idx_q <= 2'h0;
			for (i = 0; i < 4; i = i + 1) begin
				stg[i] <= 32'h00000000;
			end
		end else if (flush) begin
			stg_cnt_q <= 3'h0;
			stg_idx_q <= 2'h0;
		end else if (rx_word && stg_cnt_q == 3'h0) begin
			stg_idx_q <= 2'h0;
			if (pack) begin
				// slots 0-3 take lanes 0-3 of one channel
				for (i = 0; i < 4; i = i + 1) begin
					stg[i] <= rx_new[i];	// see RULE1
				end
				stg_cnt_q <= 3'h4;
			end else begin
				stg[0]    <= rx_new[0];	// see RULE3
				stg_cnt_q <= 3'h1;
			end
		end else if (stg_cnt_q != 3'h0 && push_ready) begin
			stg_idx_q <= stg_idx_q + 2'h1;
			stg_cnt_q <= stg_cnt_q - 3'h1;
		end
	end

	// the fifo between capture and transmit
	wire pop_ready = (tx_st_q == TX_LOAD) & ~flush;
	atc_fifo #(
		.W  (`ATC_SLOT_BITS),
		.D  (`ATC_FIFO_DEPTH),
		.AW (`ATC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.flush     (flush),
		.in_valid  (stg_cnt_q != 3'h0),
		.in_data   (stg[stg_idx_q]),
		.in_ready  (push_ready),
		.out_valid (pop_valid),
		.out_data  (pop_data),
		.out_ready (pop_ready)
	);

	// transmitter: tdm on lane 0 in pack, four i2s lanes in split
	reg [31:0] txw [0:3];		// words being sent
	reg [7:0]  tx_n_q;		// bit position in frame
	reg [1:0]  tx_ld_q;		// words loaded this slot
	reg [3:0]  tx_cnt_q;		// half period counter
	reg [3:0]  tx_prev_q;		// previous bit per lane
	wire       tx_dly  = split ? 1'b1 : dly_q;	// see RULE7
	wire       tx_pol  = split ? 1'b1 : fs_pol_q;	// see RULE7
	wire [1:0] tx_fsw  = split ? 2'b00 : fsw_q;
	wire [1:0] tx_grp  = split ? 2'h3 : 2'h0;	// last word index per slot
	wire [7:0] tx_last = split ? `ATC_PACK_LAST : `ATC_TDM_LAST;
	wire [7:0] tx_nx   = (tx_n_q == tx_last) ? 8'h00 : tx_n_q + 8'h01;
	wire [3:0] tx_cur;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_cur
			assign tx_cur[g] = txw[g][~tx_n_q[4:0]];	// msb first
		end
	endgenerate
	wire [3:0] tx_str = tx_dly ? tx_prev_q : tx_cur;	// see RULE6

	// transmit sequencer; bit clock held high while a slot loads, low before the first slot
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_st_q        <= TX_IDLE;
			tx_n_q         <= 8'h00;
			tx_ld_q        <= 2'h0;
			tx_cnt_q       <= 4'h0;
			tx_prev_q      <= 4'h0;
			aud_bclk_out_q <= 1'b0;
			aud_fs_out_q   <= 1'b0;
			aud_dout_q     <= 4'h0;
			for (i = 0; i < 4; i = i + 1) begin
				txw[i] <= 32'h00000000;
			end
		end else if (flush) begin
			tx_st_q        <= TX_IDLE;
			aud_bclk_out_q <= 1'b0;
			aud_fs_out_q   <= 1'b0;
			aud_dout_q     <= 4'h0;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					tx_n_q    <= 8'h00;
					tx_ld_q   <= 2'h0;
					tx_prev_q <= 4'h0;
					if (pack | split) begin
						tx_st_q <= TX_LOAD;
					end
				end
				TX_LOAD: begin
					if (pop_valid) begin
						txw[tx_ld_q] <= pop_data;
						if (tx_ld_q == tx_grp) begin
							tx_ld_q  <= 2'h0;
							tx_cnt_q <= 4'h0;
							tx_st_q  <= TX_LOW;
						end else begin
							tx_ld_q <= tx_ld_q + 2'h1;
						end
					end
				end
				TX_LOW: begin
					if (tx_cnt_q == 4'h0) begin
						// present bit and frame sync on the falling edge
						aud_bclk_out_q <= 1'b0;
						aud_fs_out_q   <= fs_level(tx_n_q, split, tx_fsw, tx_pol);	// see RULE5 see RULE8 see RULE4
						aud_dout_q     <= split ? tx_str : {3'h0, tx_str[0]};	// see RULE1 see RULE3
					end
					if (tx_cnt_q == `ATC_TX_HALF_CYC - 4'h1) begin
						tx_cnt_q       <= 4'h0;
						aud_bclk_out_q <= 1'b1;
						tx_st_q        <= TX_HIGH;
					end else begin
						tx_cnt_q <= tx_cnt_q + 4'h1;
					end
				end
				TX_HIGH: begin
					if (tx_cnt_q == `ATC_TX_HALF_CYC - 4'h1) begin
						tx_cnt_q  <= 4'h0;
						tx_prev_q <= tx_cur;
						tx_n_q    <= tx_nx;
						// every slot boundary fetches fresh words
						tx_st_q   <= (tx_nx[4:0] == 5'h00) ? TX_LOAD : TX_LOW;
					end else begin
						tx_cnt_q <= tx_cnt_q + 4'h1;
					end
				end
				default: begin
					tx_st_q <= TX_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// ==== sim/atc_src_model.sv ====
// i2s or tdm audio source driving the block's audio pins
// assumes the bench sets the frame fields before raising run
`timescale 1ns/1ps
`default_nettype none

module atc_src_model (
	// control
	input  wire logic              run,
	input  wire logic              pol,
	input  wire logic              dly,
	input  wire logic [11:0]       half,
	input  wire logic [8:0]        len,
	input  wire logic [8:0]        fs_len,
	input  wire logic [3:0][255:0] frame,
	// pins
	output var  logic              bclk,
	output var  logic              fs,
	output var  logic [3:0]        din
);
	logic [3:0][255:0] f;	// frame latched at its start
	logic              p, d;	// polarity and delay of this frame
	int                n, m, i, j, k;

	// bit clock runs only inside frames
	initial begin
		bclk = 1'b0;
		fs = 1'b0;
		din = 4'h0;
		forever begin
			if (!run) begin
				#(half);
				bclk = 1'b0;
				fs = pol;	// idle sync is inactive
				din = ~din;	// released lines do not hold
			end else begin
				f = frame;
				p = pol;
				d = dly;
				n = len;
				m = fs_len;
				// a dropped run cuts the frame at the next bit
				for (i = 0; i < n && run; i++) begin
					#(half);
					bclk = 1'b0;
					fs = (i < m) ? ~p : p;
					j = (i + n - d) % n;
					for (k = 0; k < 4; k++) din[k] = f[k][n - 1 - j];
					#(half);
					bclk = 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/atc_top_asserts.sv ====
// checker for the audio conversion top ports, with its own register shadow
// assumes a single clk domain and one-cycle write strobes
`timescale 1ns/1ps
`default_nettype none

module atc_top_asserts (
	// system
	input wire logic       clk,
	input wire logic       arst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_rdata_q,
	// audio pins
	input wire logic       aud_bclk_in,
	input wire logic       aud_fs_in,
	input wire logic [3:0] aud_din,
	input wire logic       aud_bclk_out_q,
	input wire logic       aud_fs_out_q,
	input wire logic [3:0] aud_dout_q
);
	logic [7:0] br_q, cv_q, tf_q;	// shadows of the three config registers
	logic       w1_q, w2_q;	// write seen one and two edges ago
	logic [7:0] nr_q;	// bit clock rises while sync is active
	wire        pack  = br_q[2] & br_q[1];
	wire        split = cv_q[7] & ~br_q[2] & br_q[1];
	wire        off   = ~pack & ~split;
	wire        fsa   = (split ? 1'b0 : ~tf_q[3]) == aud_fs_out_q;
	wire  [7:0] fsw   = split ? 8'h20 : tf_q[1] ? 8'h01 : tf_q[0] ? 8'h20 : 8'h80;

	// shadow writes with reserved bits masked, count sync width
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			br_q <= 8'h02;
			cv_q <= 8'h00;
			tf_q <= 8'h02;
			w1_q <= 1'b0;
			w2_q <= 1'b0;
			nr_q <= 8'h00;
		end else begin
			if (reg_wr && reg_addr == 8'h54) br_q <= reg_wdata & 8'h06;
			if (reg_wr && reg_addr == 8'h55) cv_q <= reg_wdata & 8'h80;
			if (reg_wr && reg_addr == 8'h57) tf_q <= reg_wdata & 8'h0F;
			w1_q <= reg_wr;
			w2_q <= w1_q;
			nr_q <= (!fsa || reg_wr) ? 8'h00 : nr_q + {7'h00, $rose(aud_bclk_out_q)};
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// no write has landed in the last two edges
	sequence hold_s;
		!reg_wr && !w1_q && !w2_q;
	endsequence

	bridge_read_a: assert property (reg_addr == 8'h54 |=> reg_rdata_q == $past(br_q))
		else $error("bridge config readback wrong");
	conv_read_a: assert property (reg_addr == 8'h55 |=> reg_rdata_q == $past(cv_q))
		else $error("conversion config readback wrong");
	fmt_read_a: assert property (reg_addr == 8'h57 |=> reg_rdata_q == $past(tf_q))
		else $error("format config readback wrong");
	idle_quiet_a: assert property (off [*4] |-> aud_bclk_out_q == 1'b0 && aud_dout_q == 4'h0)
		else $error("outputs move while audio is off");
	pack_lanes_a: assert property (pack [*4] |-> aud_dout_q[3:1] == 3'h0)
		else $error("packed output uses more than one line");
	edge_align_a: assert property (hold_s ##0 ($changed(aud_dout_q) || $changed(aud_fs_out_q))
		|-> !aud_bclk_out_q) else $error("output changed while bit clock high");
	sync_width_a: assert property (hold_s ##0 ((pack || split) && $fell(fsa)) |-> nr_q == fsw)
		else $error("frame sync width wrong");
	sync_start_a: assert property (hold_s ##0 (pack && $rose(fsa)) |-> !aud_bclk_out_q)
		else $error("frame sync raised on a rising bit clock");
endmodule

bind atc_top atc_top_asserts chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q), .aud_bclk_in(aud_bclk_in),
	.aud_fs_in(aud_fs_in), .aud_din(aud_din), .aud_bclk_out_q(aud_bclk_out_q),
	.aud_fs_out_q(aud_fs_out_q), .aud_dout_q(aud_dout_q));
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: registers, pack and split frames, audio off
// assumes the source model on the audio pins and the bound checker
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic              clk, arst_n, reg_wr;	// design inputs
	logic [7:0]        reg_addr, reg_wdata, reg_rdata_q;
	logic              aud_bclk_in, aud_fs_in, aud_bclk_out_q, aud_fs_out_q;
	logic [3:0]        aud_din, aud_dout_q;
	logic              src_run, src_pol, src_dly;	// source controls
	logic [11:0]       src_half;
	logic [8:0]        src_len, src_fsl;
	logic [3:0][255:0] src_frame;
	int                n_mismatch, checks, na;	// bookkeeping
	logic [255:0]      got [4];	// decoded output bits per lane
	logic [31:0]       exp_q [$];	// expected words of a frame
	localparam logic [31:0] ra_v = 32'h54555760;	// addresses
	localparam logic [31:0] rs_v = 32'h02000200;	// after reset
	localparam logic [31:0] rf_v = 32'h06800F00;	// after writing FF

	atc_top dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rdata_q(reg_rdata_q), .aud_bclk_in(aud_bclk_in),
		.aud_fs_in(aud_fs_in), .aud_din(aud_din), .aud_bclk_out_q(aud_bclk_out_q),
		.aud_fs_out_q(aud_fs_out_q), .aud_dout_q(aud_dout_q));
	atc_src_model src_u (.run(src_run), .pol(src_pol), .dly(src_dly), .half(src_half),
		.len(src_len), .fs_len(src_fsl), .frame(src_frame), .bclk(aud_bclk_in),
		.fs(aud_fs_in), .din(aud_din));

	// 40 MHz clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic summarize();
		if (n_mismatch == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// one register read compared with e
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		@(posedge clk);
		#1;
		chk({24'h0, reg_rdata_q}, {24'h0, e});
	endtask

	// next rising edge of the output bit clock, bounded
	task automatic brise(output logic f, output logic [3:0] d);
		int t;
		for (t = 0; t < 12000 && aud_bclk_out_q !== 1'b0; t++) begin @(posedge clk); #1; end
		for (; t < 12000 && aud_bclk_out_q !== 1'b1; t++) begin @(posedge clk); #1; end
		if (t == 12000) begin n_mismatch++; summarize(); end
		f = aud_fs_out_q;
		d = aud_dout_q;
	endtask

	// capture n bit clocks on nl lanes from the sync edge on
	task automatic grab(input logic act, input int dly, input int n, input int nl);
		logic f, p;
		logic [3:0] d;
		int i, k;
		p = act;
		for (i = 0; i < 600; i++) begin
			brise(f, d);
			if (f === act && p !== act) break;
			p = f;
		end
		if (i == 600) begin n_mismatch++; summarize(); end
		na = 0;
		for (i = 0; i < n + dly; i++) begin
			if (i > 0) brise(f, d);
			if (i < n && f === act) na++;
			for (k = 0; k < nl && i >= dly; k++) got[k] = {got[k][254:0], d[k]};
		end
	endtask

	// program a mode and format, feed random words, check one frame
	task automatic run_case(input logic sp, input logic [3:0] fmt);
		int s;
		src_run <= 1'b0;
		repeat (80) @(posedge clk);	// let a running source frame stop
		wr(8'h54, 8'h00);
		wr(8'h57, {4'h0, fmt});
		wr(8'h55, {sp, 7'h00});
		for (s = 0; s < 8; s++) exp_q.push_back($urandom);
		for (s = 0; s < 4; s++) begin
			src_frame[s] = {8{$urandom}};
			if (!sp) src_frame[s][63:0] = {exp_q[s], exp_q[s + 4]};
		end
		if (sp) src_frame[0] = {exp_q[0], exp_q[1], exp_q[2], exp_q[3], exp_q[4], exp_q[5],
			exp_q[6], exp_q[7]};
		src_pol <= sp ? fmt[3] : 1'b1;
		src_dly <= sp ? fmt[2] : 1'b1;
		src_half <= sp ? 12'h06E : 12'h384;
		src_len <= sp ? 9'h100 : 9'h040;
		src_fsl <= sp ? 9'h001 : 9'h020;
		repeat (80) @(posedge clk);	// idle levels follow the new format
		src_run <= 1'b1;
		wr(8'h54, sp ? 8'h02 : 8'h06);
		if (sp) begin
			grab(1'b0, 1, 64, 4);
			chk(na, 32);
			for (s = 0; s < 4; s++) chk(got[s][63:32], exp_q[s]);
			for (s = 0; s < 4; s++) chk(got[s][31:0], exp_q[s + 4]);
		end else begin
			grab(~fmt[3], fmt[2], 256, 1);
			chk(na, fmt[1] ? 1 : fmt[0] ? 32 : 128);
			for (s = 0; s < 8; s++) chk(got[0][255 - 32 * s -: 32], exp_q[s]);
		end
		exp_q.delete();
	endtask

	// main sequence
	initial begin
		int i, sd, bad;
		arst_n = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		src_run = 1'b0;
		src_pol = 1'b1;
		src_dly = 1'b1;
		src_half = 12'h06E;
		src_len = 9'h040;
		src_fsl = 9'h020;
		src_frame = '0;
		n_mismatch = 0;
		checks = 0;
		bad = 0;
		sd = $urandom(32'hE9F77F44);
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		for (i = 0; i < 4; i++) rdc(ra_v[31 - 8 * i -: 8], rs_v[31 - 8 * i -: 8]);
		for (i = 0; i < 4; i++) begin
			wr(ra_v[31 - 8 * i -: 8], 8'hFF);
			rdc(ra_v[31 - 8 * i -: 8], rf_v[31 - 8 * i -: 8]);
		end
		sd = $urandom;
		wr(8'h57, sd[7:0]);
		rdc(8'h57, sd[7:0] & 8'h0F);
		for (i = 0; i < 4; i++) run_case(1'b0, {i[0], i[1], i[1:0]});
		for (i = 0; i < 4; i++) run_case(1'b1, {i[0], i[1], 2'b10});
		wr(8'h54, 8'h04);
		repeat (4) @(posedge clk);
		for (i = 0; i < 2000; i++) begin
			@(posedge clk);
			#1;
			if (aud_bclk_out_q !== 1'b0 || aud_dout_q !== 4'h0) bad = 1;
		end
		chk(bad, 0);
		summarize();
	end
endmodule
`default_nettype wire
